//--- rtl/pamt_combine.sv
`timescale 1ns/1ns
`include "pamt_regs.svh"
module pamt_combine (
	input  wire logic [2:0]          attr_type,
	input  wire logic [2:0]          range_type,
	input  wire logic                range_en,
	output pamt_pkg::pamt_eff_t      eff
);
	import pamt_pkg::*;

	logic [2:0] rng;

	// Disabled range registers read as uncacheable
	assign rng = range_en ? range_type : `PAMT_TYPE_UC;

	always_comb begin
		// Undefined pairs fall to uncacheable for reproducibility, except a WC attribute, which stays WC
		eff = PAMT_EFF_UC;
		case (attr_type)
			`PAMT_TYPE_UC: begin
				if (rng == `PAMT_TYPE_UC)
					eff = PAMT_EFF_UC;
				else if (rng == `PAMT_TYPE_WC || rng == `PAMT_TYPE_WP ||
				         rng == `PAMT_TYPE_WT || rng == `PAMT_TYPE_WB)
					eff = PAMT_EFF_CD;
			end
			`PAMT_TYPE_UCM: begin
				if (rng == `PAMT_TYPE_UC)
					eff = PAMT_EFF_UC;
				else if (rng == `PAMT_TYPE_WC)
					eff = PAMT_EFF_WC;
				else if (rng == `PAMT_TYPE_WP || rng == `PAMT_TYPE_WT ||
				         rng == `PAMT_TYPE_WB)
					eff = PAMT_EFF_CD;
			end
			`PAMT_TYPE_WC: begin
				eff = PAMT_EFF_WC;
			end
			`PAMT_TYPE_WP: begin
				case (rng)
					`PAMT_TYPE_UC: eff = PAMT_EFF_UC;
					`PAMT_TYPE_WC: eff = PAMT_EFF_CD;
					`PAMT_TYPE_WP: eff = PAMT_EFF_WP;
					`PAMT_TYPE_WT: eff = PAMT_EFF_CD;
					`PAMT_TYPE_WB: eff = PAMT_EFF_WP;
					default:       eff = PAMT_EFF_UC;
				endcase
			end
			`PAMT_TYPE_WT: begin
				case (rng)
					`PAMT_TYPE_UC: eff = PAMT_EFF_UC;
					`PAMT_TYPE_WC: eff = PAMT_EFF_CD;
					`PAMT_TYPE_WP: eff = PAMT_EFF_CD;
					`PAMT_TYPE_WT: eff = PAMT_EFF_WT;
					`PAMT_TYPE_WB: eff = PAMT_EFF_WT;
					default:       eff = PAMT_EFF_UC;
				endcase
			end
			`PAMT_TYPE_WB: begin
				case (rng)
					`PAMT_TYPE_UC: eff = PAMT_EFF_UC;
					`PAMT_TYPE_WC: eff = PAMT_EFF_WC;
					`PAMT_TYPE_WP: eff = PAMT_EFF_WP;
					`PAMT_TYPE_WT: eff = PAMT_EFF_WT;
					`PAMT_TYPE_WB: eff = PAMT_EFF_WB;
					default:       eff = PAMT_EFF_UC;
				endcase
			end
			default: eff = PAMT_EFF_UC;
		endcase
	end

endmodule

//--- rtl/pamt_pkg.sv
package pamt_pkg;

	// Table level that supplied the select bits
	typedef enum logic [1:0] {
		PAMT_LVL_LEAF_4K,
		PAMT_LVL_DIR_LARGE,
		PAMT_LVL_UPPER
	} pamt_level_t;

	// Effective memory type, including the cache-disabled result
	typedef enum logic [2:0] {
		PAMT_EFF_UC,
		PAMT_EFF_WC,
		PAMT_EFF_WT,
		PAMT_EFF_WP,
		PAMT_EFF_WB,
		PAMT_EFF_CD
	} pamt_eff_t;

	typedef struct packed {
		logic        valid;
		pamt_level_t level;
		logic [12:0] entry;
		logic [2:0]  range_type;
		logic        range_en;
	} pamt_req_t;

	typedef struct packed {
		logic        valid;
		logic [2:0]  idx;
		logic [2:0]  attr_type;
		pamt_eff_t   eff;
		logic        next_level;
	} pamt_rsp_t;

endpackage

//--- rtl/pamt_regs.svh
`ifndef PAMT_REGS_SVH
`define PAMT_REGS_SVH

// ----------------------------------------
// Register map, byte addresses
// ----------------------------------------
`define PAMT_ADDR_W        5
`define PAMT_OFF_ATTR_LO   5'h00
`define PAMT_OFF_ATTR_HI   5'h04
`define PAMT_OFF_STATUS    5'h08
`define PAMT_OFF_FEATURE   5'h0C
`define PAMT_OFF_LAST      5'h10

// ----------------------------------------
// Attribute register layout
// ----------------------------------------
`define PAMT_NUM_FIELDS    8
`define PAMT_FLD_STRIDE    8
`define PAMT_TYPE_W        3
`define PAMT_IDX_W         3
`define PAMT_ATTR_RESET_LO 32'h00070406
`define PAMT_ATTR_RESET_HI 32'h00070406
`define PAMT_RSVD_MASK     32'hF8F8F8F8

// ----------------------------------------
// Memory type encodings
// ----------------------------------------
`define PAMT_TYPE_UC       3'h0
`define PAMT_TYPE_WC       3'h1
`define PAMT_TYPE_WT       3'h4
`define PAMT_TYPE_WP       3'h5
`define PAMT_TYPE_WB       3'h6
`define PAMT_TYPE_UCM      3'h7

// ----------------------------------------
// Table entry bit positions
// ----------------------------------------
`define PAMT_ENTRY_W       13
`define PAMT_LEAF_SEL_BIT  7
`define PAMT_DIR_SEL_BIT   12
`define PAMT_PCD_BIT       4
`define PAMT_PWT_BIT       3

// ----------------------------------------
// Status and feature bits
// ----------------------------------------
`define PAMT_ST_FAULT_BIT  0
`define PAMT_ST_UNMAP_BIT  1
`define PAMT_FEAT_BIT      16

`endif

//--- rtl/pamt_top.sv
`timescale 1ns/1ns
`include "pamt_regs.svh"
// Notes on behaviour
// - Select bit: leaf bit 7, directory bit 12
// - Entries without select bit use zero
// - Cache-disable select from entry bit 4
// - Write-through select from entry bit 3
// - Index is select, cache-disable, write-through
// - Reset fields: WB, WT, UC-minus, UC twice
// - Type encodings 0,1,4,5,6,7 only
// - Bad reserved bits or types fault, no update
// - Lookup always active, no disable control
// - Feature result bit 16 reports support
// - Every access picks field, applies its type
// - Upper levels index first four fields only
// - UC, UC-minus combine with range type; WC stays WC
// - WP, WT, WB combine with range type
// - Disabled range registers mean uncacheable
module pamt_top (
	input  wire logic                 clk,
	input  wire logic                 sys_rst,
	input  wire logic [4:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	input  wire logic [3:0]           avs_byteenable,
	output logic [31:0]               avs_readdata,
	output logic                      avs_waitrequest,
	input  wire pamt_pkg::pamt_req_t  lk_req,
	output pamt_pkg::pamt_rsp_t       lk_rsp,
	output logic                      protection_fault
);
	import pamt_pkg::*;

	// ----------------------------------------
	// Bus slave: one wait cycle on every access
	// ----------------------------------------
	logic        ack_r;
	logic        ack_nxt;
	logic        req_any;
	logic        wr_fire;
	logic        rd_setup;
	logic        hit_lo;
	logic        hit_hi;
	logic        hit_st;
	logic        hit_ft;
	logic        hit_last;
	logic        hit_any;
	logic [31:0] be_mask;
	logic [31:0] rd_mux;
	logic [31:0] readdata_r;

	assign req_any         = avs_read | avs_write;
	assign ack_nxt         = req_any & ~ack_r;
	assign avs_waitrequest = req_any & ~ack_r;
	assign wr_fire         = avs_write & ack_r;
	assign rd_setup        = avs_read & ~ack_r;
	assign avs_readdata    = readdata_r;

	assign hit_lo   = avs_address == `PAMT_OFF_ATTR_LO;
	assign hit_hi   = avs_address == `PAMT_OFF_ATTR_HI;
	assign hit_st   = avs_address == `PAMT_OFF_STATUS;
	assign hit_ft   = avs_address == `PAMT_OFF_FEATURE;
	assign hit_last = avs_address == `PAMT_OFF_LAST;
	assign hit_any  = hit_lo | hit_hi | hit_st | hit_ft | hit_last;

	assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
	                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	// ----------------------------------------
	// Attribute register and write checking
	// ----------------------------------------
	logic [63:0] attr_r;
	logic [63:0] attr_cand;
	logic [31:0] wr_lo;
	logic [31:0] wr_hi;
	logic [7:0]  fld_ok;
	logic        rsvd_bad;
	logic        wr_attr;
	logic        wr_bad;
	logic        wr_good;
	logic [2:0]  fld [`PAMT_NUM_FIELDS];

	assign wr_lo = (attr_r[31:0] & ~be_mask) | (avs_writedata & be_mask);
	assign wr_hi = (attr_r[63:32] & ~be_mask) | (avs_writedata & be_mask);
	assign attr_cand = hit_lo ? {attr_r[63:32], wr_lo} :
	                   hit_hi ? {wr_hi, attr_r[31:0]} : attr_r;

	// Check the whole candidate; the untouched half is already legal
	assign rsvd_bad = ((attr_cand[31:0] | attr_cand[63:32]) & `PAMT_RSVD_MASK) != 32'h0;

	genvar gi;
	generate
		for (gi = 0; gi < `PAMT_NUM_FIELDS; gi++) begin : g_fld
			logic [2:0] cand_t;
			assign cand_t = attr_cand[gi*`PAMT_FLD_STRIDE +: `PAMT_TYPE_W];
			assign fld[gi] = attr_r[gi*`PAMT_FLD_STRIDE +: `PAMT_TYPE_W];
			assign fld_ok[gi] = cand_t == `PAMT_TYPE_UC || cand_t == `PAMT_TYPE_WC ||
			                    cand_t == `PAMT_TYPE_WT || cand_t == `PAMT_TYPE_WP ||
			                    cand_t == `PAMT_TYPE_WB || cand_t == `PAMT_TYPE_UCM;
		end
	endgenerate

	assign wr_attr = wr_fire & (hit_lo | hit_hi);
	assign wr_bad  = wr_attr & (rsvd_bad | ~&fld_ok);
	assign wr_good = wr_attr & ~wr_bad;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			attr_r <= {`PAMT_ATTR_RESET_HI, `PAMT_ATTR_RESET_LO};
		end else if (wr_good) begin
			attr_r <= attr_cand;
		end
	end

	// ----------------------------------------
	// Status: fault and unmapped, write one to clear
	// ----------------------------------------
	logic        fault_r;
	logic        fault_nxt;
	logic        unmap_r;
	logic        unmap_nxt;
	logic        st_clr_fault;
	logic        st_clr_unmap;
	logic        unmap_ev;
	logic        pf_r;

	assign st_clr_fault = wr_fire & hit_st & avs_byteenable[0] &
	                      avs_writedata[`PAMT_ST_FAULT_BIT];
	assign st_clr_unmap = wr_fire & hit_st & avs_byteenable[0] &
	                      avs_writedata[`PAMT_ST_UNMAP_BIT];
	assign unmap_ev     = req_any & ack_r & ~hit_any;
	// Set beats clear in the same cycle so no event is lost
	assign fault_nxt    = wr_bad | (fault_r & ~st_clr_fault);
	assign unmap_nxt    = unmap_ev | (unmap_r & ~st_clr_unmap);
	assign protection_fault = pf_r;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fault_r <= 1'b0;
			unmap_r <= 1'b0;
			pf_r    <= 1'b0;
		end else begin
			fault_r <= fault_nxt;
			unmap_r <= unmap_nxt;
			pf_r    <= wr_bad;
		end
	end

	// ----------------------------------------
	// Lookup: select bits, index, combine
	// ----------------------------------------
	logic        sel_attr;
	logic        sel_pcd;
	logic        sel_pwt;
	logic [2:0]  idx;
	logic [2:0]  fld_type;
	pamt_eff_t   eff;
	pamt_rsp_t   rsp_r;
	pamt_rsp_t   rsp_nxt;

	// Walker hands over the leaf or directory copy per paging mode
	assign sel_attr = (lk_req.level == PAMT_LVL_LEAF_4K)   ? lk_req.entry[`PAMT_LEAF_SEL_BIT] :
	                  (lk_req.level == PAMT_LVL_DIR_LARGE) ? lk_req.entry[`PAMT_DIR_SEL_BIT]  :
	                  1'b0;
	assign sel_pcd  = lk_req.entry[`PAMT_PCD_BIT];
	assign sel_pwt  = lk_req.entry[`PAMT_PWT_BIT];
	// Upper levels land in fields 0 to 3 since sel_attr is zero there
	assign idx      = {sel_attr, sel_pcd, sel_pwt};
	// No enable term exists: the table is always consulted
	assign fld_type = fld[idx];

	pamt_combine u_combine (
		.attr_type  (fld_type),
		.range_type (lk_req.range_type),
		.range_en   (lk_req.range_en),
		.eff        (eff)
	);

	always_comb begin
		rsp_nxt            = rsp_r;
		rsp_nxt.valid      = lk_req.valid;
		if (lk_req.valid) begin
			rsp_nxt.idx        = idx;
			rsp_nxt.attr_type  = fld_type;
			rsp_nxt.eff        = eff;
			rsp_nxt.next_level = lk_req.level == PAMT_LVL_UPPER;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rsp_r <= '{valid: 1'b0, idx: 3'h0, attr_type: 3'h0,
			           eff: PAMT_EFF_UC, next_level: 1'b0};
		end else begin
			rsp_r <= rsp_nxt;
		end
	end

	assign lk_rsp = rsp_r;

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	logic [31:0] st_word;
	logic [31:0] ft_word;
	logic [31:0] last_word;

	assign st_word   = {30'h0, unmap_r, fault_r};
	assign ft_word   = 32'h1 << `PAMT_FEAT_BIT;
	assign last_word = {22'h0, rsp_r.next_level, 3'(rsp_r.eff), rsp_r.attr_type,
	                    rsp_r.idx[2:1], rsp_r.idx[0]};
	assign rd_mux    = hit_lo   ? attr_r[31:0]  :
	                   hit_hi   ? attr_r[63:32] :
	                   hit_st   ? st_word       :
	                   hit_ft   ? ft_word       :
	                   hit_last ? last_word     : 32'h0;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ack_r      <= 1'b0;
			readdata_r <= 32'h0;
		end else begin
			ack_r <= ack_nxt;
			if (rd_setup)
				readdata_r <= rd_mux;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_bus_req;
		req_any && avs_waitrequest;
	endsequence

	sequence s_bus_ans;
		!avs_waitrequest;
	endsequence

	property p_bus_one_wait;
		s_bus_req |=> s_bus_ans;
	endproperty
	a_bus_one_wait: assert property (p_bus_one_wait) else $error("bus answer late");

	property p_attr_hold;
		!wr_good |=> $stable(attr_r);
	endproperty
	a_attr_hold: assert property (p_attr_hold) else $error("attr changed w/o write");

	property p_bad_write;
		wr_bad |=> $stable(attr_r) && protection_fault && fault_r;
	endproperty
	a_bad_write: assert property (p_bad_write) else $error("bad write not faulted");

	property p_leaf_index;
		lk_req.valid && lk_req.level == PAMT_LVL_LEAF_4K |=>
			lk_rsp.idx == $past({lk_req.entry[`PAMT_LEAF_SEL_BIT], lk_req.entry[`PAMT_PCD_BIT],
			                     lk_req.entry[`PAMT_PWT_BIT]});
	endproperty
	a_leaf_index: assert property (p_leaf_index) else $error("leaf index wrong");

	property p_dir_index;
		lk_req.valid && lk_req.level == PAMT_LVL_DIR_LARGE |=>
			lk_rsp.idx == $past({lk_req.entry[`PAMT_DIR_SEL_BIT], lk_req.entry[`PAMT_PCD_BIT],
			                     lk_req.entry[`PAMT_PWT_BIT]});
	endproperty
	a_dir_index: assert property (p_dir_index) else $error("directory index wrong");

	property p_upper_low;
		lk_req.valid && lk_req.level == PAMT_LVL_UPPER |=>
			lk_rsp.valid && !lk_rsp.idx[2] && lk_rsp.next_level;
	endproperty
	a_upper_low: assert property (p_upper_low) else $error("upper level index high");

	property p_type_read;
		lk_req.valid |=> lk_rsp.attr_type == $past(fld_type);
	endproperty
	a_type_read: assert property (p_type_read) else $error("field type not applied");

	property p_wc_attr;
		lk_req.valid && fld_type == `PAMT_TYPE_WC |=> lk_rsp.eff == PAMT_EFF_WC;
	endproperty
	a_wc_attr: assert property (p_wc_attr) else $error("WC attr not WC");

	property p_range_off;
		lk_req.valid && !lk_req.range_en && fld_type == `PAMT_TYPE_WB |=>
			lk_rsp.eff == PAMT_EFF_UC;
	endproperty
	a_range_off: assert property (p_range_off) else $error("disabled range not UC");

	property p_feature;
		avs_read && hit_ft && !avs_waitrequest |-> avs_readdata[`PAMT_FEAT_BIT];
	endproperty
	a_feature: assert property (p_feature) else $error("feature bit missing");

endmodule

//--- verification/pamt_top_tb.sv
`timescale 1ns/1ns
module pamt_top_tb;
	import pamt_pkg::*;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        protection_fault;
	pamt_req_t   lk_req;
	pamt_rsp_t   lk_rsp;
	int          mismatches = 0;
	int          checks = 0;
	int          attr[8];
	logic [9:0]  expq[$];
	logic [9:0]  lk_exp;
	logic [9:0]  lk_last;
	logic [31:0] q;

	pamt_top dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .lk_req(lk_req), .lk_rsp(lk_rsp),
		.protection_fault(protection_fault));
	pamt_walker walker (.clk(clk), .lk_req(lk_req));

	always #4 clk = ~clk;

	// ----------------------------------------
	// Reporting
	// ----------------------------------------
	task automatic results();
		$display("mismatches=%0d checks=%0d", mismatches, checks);
		if (mismatches == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic cmp_lk(input logic [9:0] g, input logic [9:0] e);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask

	// ----------------------------------------
	// Model
	// ----------------------------------------
	// Result codes: UC 0, WC 1, WT 2, WP 3, WB 4, CD 5
	function automatic int comb(input int a, input int r, input bit en);
		if (!en) r = 0;
		// Write-combining attribute wins over any range code
		if (a == 1) return 1;
		if (!(r inside {0, 1, 4, 5, 6})) return 0;
		case (a)
			0: return r == 0 ? 0 : 5;
			7: return r == 0 ? 0 : r == 1 ? 1 : 5;
			1: return 1;
			5: return r == 0 ? 0 : (r == 1 || r == 4) ? 5 : 3;
			4: return r == 0 ? 0 : (r == 1 || r == 5) ? 5 : 2;
			6: return r == 0 ? 0 : r == 1 ? 1 : r == 5 ? 3 : r == 4 ? 2 : 4;
			default: return 0;
		endcase
	endfunction

	function automatic logic [31:0] pk(input int h);
		for (int i = 0; i < 4; i++) pk[i*8 +: 8] = 8'(attr[h*4 + i]);
	endfunction

	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (n > 50) begin
				mismatches++;
				results();
			end
		end while (avs_waitrequest !== 1'b0);
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wattr(input int h, input logic [31:0] d);
		logic [63:0] nw;
		bit          ok;
		nw = {pk(1), pk(0)};
		nw[h*32 +: 32] = d;
		ok = 1;
		for (int i = 0; i < 8; i++) if (!(nw[i*8 +: 8] inside {0, 1, 4, 5, 6, 7})) ok = 0;
		bus(1'b1, h ? 5'h04 : 5'h00, d, q);
		@(posedge clk);
		cmp_reg({31'h0, protection_fault}, {31'h0, !ok});
		if (ok) for (int i = 0; i < 8; i++) attr[i] = nw[i*8 +: 8];
		bus(1'b0, h ? 5'h04 : 5'h00, 32'h0, q);
		cmp_reg(q, pk(h));
	endtask

	task automatic look(input int lv, input logic [12:0] e, input logic [2:0] rt,
		input logic en);
		logic       s;
		logic [2:0] ix;
		s = lv == 0 ? e[7] : lv == 1 ? e[12] : 1'b0;
		ix = {s, e[4], e[3]};
		lk_last = {lv == 2, ix, 3'(attr[ix]), 3'(comb(attr[ix], rt, en))};
		expq.push_back(lk_last);
		walker.send(pamt_level_t'(lv), e, rt, en);
	endtask

	task automatic rlook(input int n);
		int rt[6] = '{0, 1, 4, 5, 6, 2};
		repeat (n) look($urandom % 3, 13'($urandom), 3'(rt[$urandom % 6]), 1'($urandom));
		walker.idle();
		repeat (3) @(posedge clk);
		cmp_reg(32'(expq.size()), 32'h0);
		bus(1'b0, 5'h10, 32'h0, q);
		cmp_reg(q, {22'h0, lk_last[9], lk_last[2:0], lk_last[5:3], lk_last[8:6]});
	endtask

	task automatic reset_chk();
		for (int i = 0; i < 8; i++) attr[i] = i % 4 == 0 ? 6 : i % 4 == 1 ? 4 : i % 4 == 2 ? 7 : 0;
		bus(1'b0, 5'h00, 32'h0, q);
		cmp_reg(q, pk(0));
		bus(1'b0, 5'h04, 32'h0, q);
		cmp_reg(q, pk(1));
		bus(1'b0, 5'h0C, 32'h0, q);
		cmp_reg(q, 32'h00010000);
		bus(1'b0, 5'h14, 32'h0, q);
		cmp_reg(q, 32'h0);
		bus(1'b0, 5'h08, 32'h0, q);
		cmp_reg(q, 32'h2);
	endtask

	// Responses arrive one cycle after each request, in order
	always @(posedge clk) begin
		if (lk_rsp.valid === 1'b1) begin
			lk_exp = expq.size() ? expq.pop_front() : 10'bx;
			cmp_lk({lk_rsp.next_level, lk_rsp.idx, lk_rsp.attr_type, lk_rsp.eff}, lk_exp);
		end
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		void'($urandom(84614));
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		reset_chk();
		bus(1'b1, 5'h08, 32'h3, q);
		bus(1'b1, 5'h0C, 32'h0, q);
		bus(1'b0, 5'h0C, 32'h0, q);
		cmp_reg(q, 32'h00010000);
		bus(1'b0, 5'h08, 32'h0, q);
		cmp_reg(q, 32'h0);
		rlook(64);
		// Lookups are paused while the table is rewritten, as software must
		for (int k = 0; k < 4; k++) begin
			int t[6] = '{0, 1, 4, 5, 6, 7};
			for (int h = 0; h < 2; h++)
				wattr(h, {8'(t[$urandom % 6]), 8'(t[$urandom % 6]), 8'(t[$urandom % 6]),
					8'(t[$urandom % 6])});
			rlook(48);
		end
		for (int h = 0; h < 2; h++) begin
			logic [31:0] bad[4] = '{32'h00000008, 32'h00000002, 32'h03000000, 32'h80000000};
			for (int b = 0; b < 4; b++) wattr(h, pk(h) ^ bad[b]);
		end
		bus(1'b0, 5'h08, 32'h0, q);
		cmp_reg(q, 32'h1);
		rlook(32);
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		reset_chk();
		rlook(32);
		results();
	end
endmodule

//--- verification/pamt_walker.sv
`timescale 1ns/1ns
module pamt_walker (
	input  wire logic           clk,
	output pamt_pkg::pamt_req_t lk_req
);
	import pamt_pkg::*;

	initial lk_req = '0;

	// Walker already picked the leaf or directory copy of the cache bits
	task automatic send(input pamt_level_t lv, input logic [12:0] e, input logic [2:0] rt,
		input logic en);
		@(posedge clk);
		lk_req <= '{valid: 1'b1, level: lv, entry: e, range_type: rt, range_en: en};
	endtask

	// Released fields are scrambled so a stale entry never looks valid
	task automatic idle();
		@(posedge clk);
		lk_req <= '{valid: 1'b0, level: PAMT_LVL_UPPER, entry: ~lk_req.entry,
			range_type: ~lk_req.range_type, range_en: ~lk_req.range_en};
	endtask
endmodule
